// *** common/nand_ecc_consts.svh ***
`ifndef NAND_ECC_CONSTS_SVH
`define NAND_ECC_CONSTS_SVH

// register indices on the register port
`define IDX_CHECK_MEMORY_CONFIG   3'h0
`define IDX_CHECK_START_OPCODES   3'h1
`define IDX_CHECK_COLUMN_OPCODES  3'h2
`define IDX_CHECK_OP_ADDRESS_LOW  3'h3
`define IDX_CHECK_OP_ADDRESS_HIGH 3'h4
`define IDX_CHECK_ENGINE_STATE    3'h5

// configuration fields
`define CFG_W              8
`define CFG_SKIP_EIGHT_BIT 7
`define CFG_JUMP_LSB       5
`define CFG_READ_END_BIT   4
`define CFG_MODE_LSB       2
`define CFG_PAGE_LSB       0
`define CFG_RESET          8'h01

// opcode register fields
`define CMD_W              25
`define CMD_WR_LSB         0
`define CMD_RD_LSB         8
`define CMD_END_LSB        16
`define CMD_END_VALID_BIT  24
`define START_CMD_RESET    25'h130_0080
`define COLUMN_CMD_RESET   25'h1E0_0585

// engine state fields
`define STATE_BUSY_BIT     6
`define ADDR_HIGH_W        24

// page structure
`define BLOCK_BYTES        512

`endif

// *** common/nand_ecc_pkg.sv ***
package nand_ecc_pkg;

    typedef enum logic [1:0] {
        MODE_BYPASS,
        MODE_CALC_ONLY,
        MODE_CALC_STORE,
        MODE_RESERVED
    } check_mode_t;

    typedef enum logic [1:0] {
        JUMP_NONE,
        JUMP_COLUMN_CHANGE,
        JUMP_FULL_COMMAND,
        JUMP_RESERVED
    } jump_mode_t;

    typedef enum logic [1:0] {
        TRK_IDLE,
        TRK_READ_PENDING,
        TRK_COLUMN_PENDING
    } track_state_t;

endpackage

// *** core/check_op_tracker.sv ***
`timescale 1ns/1ns
`include "nand_ecc_consts.svh"

module check_op_tracker #(
    parameter int ADDR_W = 56
) (
    input  wire logic              ref_clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              enable_i,
    input  wire logic              suppress_bit_eight_i,
    input  wire logic [`CMD_W-1:0] start_cmds_i,
    input  wire logic [`CMD_W-1:0] column_cmds_i,
    input  wire logic              cmd_valid_i,
    input  wire logic [7:0]        cmd_opcode_i,
    input  wire logic              addr_valid_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    output logic                   start_write_o,
    output logic                   start_read_o,
    output logic                   reposition_o,
    output logic                   op_read_o,
    output logic [ADDR_W-1:0]      op_addr_o
);

    nand_ecc_pkg::track_state_t state_reg;
    nand_ecc_pkg::track_state_t state_next;
    logic              collect_reg;
    logic              collect_next;
    logic              start_write_next;
    logic              start_read_next;
    logic              reposition_next;
    logic              op_read_next;
    logic [ADDR_W-1:0] op_addr_next;
    logic [ADDR_W-1:0] addr_masked;
    logic              hit_wr;
    logic              hit_rd;
    logic              hit_end;
    logic              hit_col_wr;
    logic              hit_col_rd;
    logic              hit_col_end;

    ////////////////////////////////////////////////////////////////////////
    // R12: opcode matching
    assign hit_wr  = cmd_opcode_i == start_cmds_i[`CMD_WR_LSB +: 8];
    assign hit_rd  = cmd_opcode_i == start_cmds_i[`CMD_RD_LSB +: 8];
    assign hit_end = cmd_opcode_i == start_cmds_i[`CMD_END_LSB +: 8];
    assign hit_col_wr  = cmd_opcode_i == column_cmds_i[`CMD_WR_LSB +: 8];
    assign hit_col_rd  = cmd_opcode_i == column_cmds_i[`CMD_RD_LSB +: 8];
    assign hit_col_end = cmd_opcode_i == column_cmds_i[`CMD_END_LSB +: 8];

    // R1: bit eight masked
    always_comb
    begin
        addr_masked = addr_i;
        if (suppress_bit_eight_i)
            addr_masked[8] = 1'b0;
    end

    always_comb
    begin
        state_next       = state_reg;
        collect_next     = collect_reg;
        start_write_next = 1'b0;
        start_read_next  = 1'b0;
        reposition_next  = 1'b0;
        op_read_next     = op_read_o;
        op_addr_next     = op_addr_o;
        // R22: address follows the start opcode
        if (addr_valid_i && collect_reg)
            op_addr_next = addr_masked;
        if (cmd_valid_i && enable_i)
        begin
            state_next   = nand_ecc_pkg::TRK_IDLE;
            collect_next = 1'b0;
            unique case (state_reg)
                nand_ecc_pkg::TRK_READ_PENDING:
                begin
                    // R15: trailing opcode completes read
                    if (hit_end)
                        start_read_next = 1'b1;
                end
                nand_ecc_pkg::TRK_COLUMN_PENDING:
                begin
                    if (hit_col_end)
                        reposition_next = 1'b1;
                end
                nand_ecc_pkg::TRK_IDLE:
                begin
                end
            endcase
            // R13: program opcode opens a write
            if (hit_wr)
            begin
                start_write_next = 1'b1;
                op_read_next     = 1'b0;
                collect_next     = 1'b1;
            end
            // R14: read opcode opens a read
            else if (hit_rd)
            begin
                op_read_next = 1'b1;
                collect_next = 1'b1;
                if (start_cmds_i[`CMD_END_VALID_BIT])
                    state_next = nand_ecc_pkg::TRK_READ_PENDING;
                else
                    start_read_next = 1'b1;
            end
            // R16: column-change opcodes
            else if (hit_col_wr)
                reposition_next = 1'b1;
            else if (hit_col_rd)
            begin
                if (column_cmds_i[`CMD_END_VALID_BIT])
                    state_next = nand_ecc_pkg::TRK_COLUMN_PENDING;
                else
                    reposition_next = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            state_reg     <= nand_ecc_pkg::TRK_IDLE;
            collect_reg   <= 1'b0;
            start_write_o <= 1'b0;
            start_read_o  <= 1'b0;
            reposition_o  <= 1'b0;
            op_read_o     <= 1'b0;
            op_addr_o     <= '0;
        end
        else
        begin
            state_reg     <= state_next;
            collect_reg   <= collect_next;
            start_write_o <= start_write_next;
            start_read_o  <= start_read_next;
            reposition_o  <= reposition_next;
            op_read_o     <= op_read_next;
            op_addr_o     <= op_addr_next;
        end
    end

endmodule // check_op_tracker

// *** core/nand_ecc_config_control.sv ***
`timescale 1ns/1ns
`include "nand_ecc_consts.svh"

// Behaviour
// R1: bit 7 set suppresses address bit eight
// R2: jump zero: check values at page end
// R3: jump one column change, two full command
// R4: read-end clear: per-block read, 512 boundary
// R5: read-end set: all values at page end
// R6: mode zero bypasses, three reserved
// R7: mode one computes, never transfers
// R8: mode two transfers, compares on read
// R9: page field gives one, two, four blocks
// R10: page zero only with extra block
// R11: no config writes while busy
// R12: start recognised on programmed opcode match
// R13: program opcode bits 7:0, reset 0x80
// R14: read opcode bits 15:8, reset 0x00
// R15: trailing read opcode 0x30, enable bit 24
// R16: column-change opcodes in second register
// R17: column register resets for open standard
// R18: low address word read-only
// R19: high address bits 23:0, top reads zero
// R20: reserved opcode bits written zero
// R21: busy status bit 6
// R22: start address held until next start
module nand_ecc_config_control #(
    parameter int ADDR_W = 56
) (
    input  wire logic              ref_clk_i,
    input  wire logic              rst_n_i,
    input  wire logic [2:0]        reg_index_i,
    input  wire logic              reg_write_i,
    input  wire logic              reg_read_i,
    input  wire logic [31:0]       reg_wdata_i,
    output logic      [31:0]       reg_rdata_o,
    output logic                   reg_rvalid_o,
    input  wire logic              cmd_valid_i,
    input  wire logic [7:0]        cmd_opcode_i,
    input  wire logic              addr_valid_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic              op_done_i,
    output logic                   busy_o,
    output logic                   calc_enable_o,
    output logic                   mem_transfer_o,
    output logic                   compare_on_read_o,
    output logic                   col_jump_o,
    output logic                   full_jump_o,
    output logic                   page_end_only_o,
    output logic                   read_per_block_o,
    output logic                   addr_bit_eight_en_o,
    output logic      [2:0]        page_blocks_o,
    output logic                   start_write_o,
    output logic                   start_read_o,
    output logic                   reposition_o,
    output logic                   op_read_o,
    output logic [ADDR_W-1:0]      op_addr_o
);

    logic [`CFG_W-1:0] cfg_reg;
    logic [`CFG_W-1:0] cfg_next;
    logic [`CMD_W-1:0] start_cmd_reg;
    logic [`CMD_W-1:0] start_cmd_next;
    logic [`CMD_W-1:0] col_cmd_reg;
    logic [`CMD_W-1:0] col_cmd_next;
    logic [31:0]       rdata_next;
    logic              busy_next;
    logic              calc_next;
    logic              transfer_next;
    logic              compare_next;
    logic              col_jump_next;
    logic              full_jump_next;
    logic              page_end_next;
    logic              per_block_next;
    logic [2:0]        blocks_next;
    logic              engine_on;
    logic              trk_start_wr;
    logic              trk_start_rd;
    logic              trk_repos;
    logic              any_start;
    nand_ecc_pkg::check_mode_t mode;
    nand_ecc_pkg::jump_mode_t  jump;

    assign mode = nand_ecc_pkg::check_mode_t'(cfg_reg[`CFG_MODE_LSB +: 2]);
    assign jump = nand_ecc_pkg::jump_mode_t'(cfg_reg[`CFG_JUMP_LSB +: 2]);

    ////////////////////////////////////////////////////////////////////////
    // R6: bypass and reserved mode disable matching
    assign engine_on = (mode == nand_ecc_pkg::MODE_CALC_ONLY)
                    || (mode == nand_ecc_pkg::MODE_CALC_STORE);

    check_op_tracker #(
        .ADDR_W (ADDR_W)
    ) u_tracker (
        .ref_clk_i     (ref_clk_i),
        .rst_n_i       (rst_n_i),
        .enable_i      (engine_on),
        .suppress_bit_eight_i (cfg_reg[`CFG_SKIP_EIGHT_BIT]),
        .start_cmds_i  (start_cmd_reg),
        .column_cmds_i (col_cmd_reg),
        .cmd_valid_i   (cmd_valid_i),
        .cmd_opcode_i  (cmd_opcode_i),
        .addr_valid_i  (addr_valid_i),
        .addr_i        (addr_i),
        .start_write_o (trk_start_wr),
        .start_read_o  (trk_start_rd),
        .reposition_o  (trk_repos),
        .op_read_o     (op_read_o),
        .op_addr_o     (op_addr_o)
    );

    assign start_write_o = trk_start_wr;
    assign start_read_o  = trk_start_rd;
    assign any_start     = trk_start_wr || trk_start_rd;

    ////////////////////////////////////////////////////////////////////////
    // register port
    always_comb
    begin
        cfg_next       = cfg_reg;
        start_cmd_next = start_cmd_reg;
        col_cmd_next   = col_cmd_reg;
        if (reg_write_i)
        begin
            unique case (reg_index_i)
                // R11: config writes while busy are dropped, config stays coherent
                `IDX_CHECK_MEMORY_CONFIG:
                    if (!busy_o)
                        cfg_next = reg_wdata_i[`CFG_W-1:0];
                // R20: reserved bits not stored
                `IDX_CHECK_START_OPCODES:
                    start_cmd_next = reg_wdata_i[`CMD_W-1:0];
                `IDX_CHECK_COLUMN_OPCODES:
                    col_cmd_next = reg_wdata_i[`CMD_W-1:0];
                default:
                begin
                end
            endcase
        end
    end

    always_comb
    begin
        rdata_next = 32'h0000_0000;
        unique case (reg_index_i)
            `IDX_CHECK_MEMORY_CONFIG:
                rdata_next[`CFG_W-1:0] = cfg_reg;
            `IDX_CHECK_START_OPCODES:
                rdata_next[`CMD_W-1:0] = start_cmd_reg;
            `IDX_CHECK_COLUMN_OPCODES:
                rdata_next[`CMD_W-1:0] = col_cmd_reg;
            // R18: low address word
            `IDX_CHECK_OP_ADDRESS_LOW:
                rdata_next = op_addr_o[31:0];
            // R19: high address, top byte zero
            `IDX_CHECK_OP_ADDRESS_HIGH:
                rdata_next[`ADDR_HIGH_W-1:0] = op_addr_o[ADDR_W-1:32];
            // R21: busy status bit
            `IDX_CHECK_ENGINE_STATE:
                rdata_next[`STATE_BUSY_BIT] = busy_o;
            default:
                rdata_next = 32'h0000_0000;
        endcase
        if (!reg_read_i)
            rdata_next = reg_rdata_o;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            cfg_reg       <= `CFG_RESET;
            // R13: write opcode reset, R14: read opcode reset
            start_cmd_reg <= `START_CMD_RESET;
            // R17: column opcodes reset
            col_cmd_reg   <= `COLUMN_CMD_RESET;
            reg_rdata_o   <= 32'h0000_0000;
            reg_rvalid_o  <= 1'b0;
        end
        else
        begin
            cfg_reg       <= cfg_next;
            start_cmd_reg <= start_cmd_next;
            col_cmd_reg   <= col_cmd_next;
            reg_rdata_o   <= rdata_next;
            reg_rvalid_o  <= reg_read_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // engine state and decoded controls
    always_comb
    begin
        // R21: busy from start to done, start wins a tie
        busy_next = busy_o;
        if (op_done_i)
            busy_next = 1'b0;
        if (any_start)
            busy_next = 1'b1;
        // R7: compute without memory transfer
        calc_next     = engine_on;
        // R8: transfer and compare only in mode two
        transfer_next = mode == nand_ecc_pkg::MODE_CALC_STORE;
        compare_next  = transfer_next && op_read_o;
        // R2: no jumping, values at page end
        page_end_next  = jump == nand_ecc_pkg::JUMP_NONE;
        // R3: column change versus full command
        col_jump_next  = jump == nand_ecc_pkg::JUMP_COLUMN_CHANGE;
        full_jump_next = jump == nand_ecc_pkg::JUMP_FULL_COMMAND;
        // R4: per-block read, R5: all at page end
        per_block_next = !cfg_reg[`CFG_READ_END_BIT];
        // R9: page blocks; R10 encoding zero gives none
        unique case (cfg_reg[`CFG_PAGE_LSB +: 2])
            2'h1:    blocks_next = 3'h1;
            2'h2:    blocks_next = 3'h2;
            2'h3:    blocks_next = 3'h4;
            default: blocks_next = 3'h0;
        endcase
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            busy_o              <= 1'b0;
            calc_enable_o       <= 1'b0;
            mem_transfer_o      <= 1'b0;
            compare_on_read_o   <= 1'b0;
            col_jump_o          <= 1'b0;
            full_jump_o         <= 1'b0;
            page_end_only_o     <= 1'b1;
            read_per_block_o    <= 1'b1;
            addr_bit_eight_en_o <= 1'b1;
            page_blocks_o       <= 3'h1;
            reposition_o        <= 1'b0;
        end
        else
        begin
            busy_o              <= busy_next;
            calc_enable_o       <= calc_next;
            mem_transfer_o      <= transfer_next;
            compare_on_read_o   <= compare_next;
            col_jump_o          <= col_jump_next;
            full_jump_o         <= full_jump_next;
            page_end_only_o     <= page_end_next;
            read_per_block_o    <= per_block_next;
            // R1: drive flag for address bit eight
            addr_bit_eight_en_o <= !cfg_reg[`CFG_SKIP_EIGHT_BIT];
            page_blocks_o       <= blocks_next;
            // R3: column repositioning only in jump mode one
            reposition_o        <= trk_repos && col_jump_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence read_opened_s;
        cmd_valid_i && engine_on && !busy_o
        && cmd_opcode_i == start_cmd_reg[`CMD_RD_LSB +: 8]
        && start_cmd_reg[`CMD_END_VALID_BIT];
    endsequence

    sequence read_closed_s;
        cmd_valid_i && engine_on
        && cmd_opcode_i == start_cmd_reg[`CMD_END_LSB +: 8];
    endsequence

    sequence write_opened_s;
        cmd_valid_i && engine_on
        && cmd_opcode_i == start_cmd_reg[`CMD_WR_LSB +: 8];
    endsequence

    read_start_seq_a: assert property ( // R15
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        read_opened_s ##1 (!cmd_valid_i) [*3] ##1 read_closed_s
        |=> start_read_o ##1 busy_o)
        else $error("read start sequence not recognised");

    write_start_a: assert property ( // R13
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        write_opened_s |=> start_write_o ##1 busy_o)
        else $error("write opcode did not start operation");

    bypass_no_start_a: assert property ( // R6
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        cmd_valid_i && mode == nand_ecc_pkg::MODE_BYPASS
        |=> !start_write_o && !start_read_o)
        else $error("operation started in bypass mode");

    busy_clear_a: assert property ( // R21
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        busy_o && op_done_i && !any_start |=> !busy_o)
        else $error("busy did not clear on completion");

    cfg_guard_a: assert property ( // R11
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        busy_o && reg_write_i
        && reg_index_i == `IDX_CHECK_MEMORY_CONFIG |=> $stable(cfg_reg))
        else $error("configuration changed while busy");

    addr_low_read_a: assert property ( // R18
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        reg_read_i && reg_index_i == `IDX_CHECK_OP_ADDRESS_LOW
        |=> reg_rvalid_o && reg_rdata_o == $past(op_addr_o[31:0]))
        else $error("low address read mismatch");

    addr_high_top_a: assert property ( // R19
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        reg_read_i && reg_index_i == `IDX_CHECK_OP_ADDRESS_HIGH
        |=> reg_rdata_o[31:24] == 8'h00)
        else $error("high address top byte not zero");

    transfer_mode_a: assert property ( // R7
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        mode == nand_ecc_pkg::MODE_CALC_ONLY |=> calc_enable_o
        && !mem_transfer_o && !compare_on_read_o)
        else $error("mode one moved check values");

    bit_eight_drive_a: assert property ( // R1
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        cfg_reg[`CFG_SKIP_EIGHT_BIT] ##1
        addr_valid_i && cfg_reg[`CFG_SKIP_EIGHT_BIT]
        |=> !addr_bit_eight_en_o && (op_addr_o[8] == 1'b0
            || $stable(op_addr_o)))
        else $error("address bit eight not suppressed");

    page_blocks_a: assert property ( // R9
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        cfg_reg[`CFG_PAGE_LSB +: 2] == 2'h3 |=> page_blocks_o == 3'h4)
        else $error("page of four blocks misdecoded");

endmodule // nand_ecc_config_control

// *** verif/nand_flash_model.sv ***
`timescale 1ns/1ns

module nand_flash_model (
    input  wire logic        ref_clk_i,
    output logic             cmd_valid_o,
    output logic [7:0]       cmd_opcode_o,
    output logic             addr_valid_o,
    output logic [55:0]      addr_o
);
    initial
    begin
        cmd_valid_o  = 1'b0;
        cmd_opcode_o = 8'h5a;
        addr_valid_o = 1'b0;
        addr_o       = 56'h0;
    end

    ////////////////////////////////////////////////////////////////////
    // released lines show the inverse, never a stale copy
    task automatic send_cmd(input logic [7:0] op);
        @(posedge ref_clk_i);
        #1;
        cmd_valid_o  = 1'b1;
        cmd_opcode_o = op;
        @(posedge ref_clk_i);
        #1;
        cmd_valid_o  = 1'b0;
        cmd_opcode_o = ~op;
    endtask

    task automatic send_addr(input logic [55:0] a);
        @(posedge ref_clk_i);
        #1;
        addr_valid_o = 1'b1;
        addr_o       = a;
        @(posedge ref_clk_i);
        #1;
        addr_valid_o = 1'b0;
        addr_o       = ~a;
    endtask
endmodule // nand_flash_model

// *** verif/nand_ecc_config_control_tb_top.sv ***
`timescale 1ns/1ns

module nand_ecc_config_control_tb_top;
    logic        ref_clk_i = 1'b0;
    logic        rst_n_i;
    logic [2:0]  reg_index_i;
    logic        reg_write_i;
    logic        reg_read_i;
    logic [31:0] reg_wdata_i;
    logic [31:0] reg_rdata_o;
    logic        reg_rvalid_o;
    logic        cmd_valid_i;
    logic [7:0]  cmd_opcode_i;
    logic        addr_valid_i;
    logic [55:0] addr_i;
    logic        op_done_i;
    logic        busy_o;
    logic        calc_enable_o;
    logic        mem_transfer_o;
    logic        compare_on_read_o;
    logic        col_jump_o;
    logic        full_jump_o;
    logic        page_end_only_o;
    logic        read_per_block_o;
    logic        addr_bit_eight_en_o;
    logic [2:0]  page_blocks_o;
    logic        start_write_o;
    logic        start_read_o;
    logic        reposition_o;
    logic        op_read_o;
    logic [55:0] op_addr_o;
    logic [31:0] exp_q[$];
    logic [31:0] lfsr_state = 32'he832_b0e3;
    logic [31:0] r;
    logic [7:0]  c;
    logic [55:0] a;
    int          fail_count = 0;
    int          n_checks = 0;
    int          n_wr = 0;
    int          n_rd = 0;
    int          n_rep = 0;

    nand_ecc_config_control #(.ADDR_W(56)) i_dut (
        .ref_clk_i (ref_clk_i),
        .rst_n_i (rst_n_i),
        .reg_index_i (reg_index_i),
        .reg_write_i (reg_write_i),
        .reg_read_i (reg_read_i),
        .reg_wdata_i (reg_wdata_i),
        .reg_rdata_o (reg_rdata_o),
        .reg_rvalid_o (reg_rvalid_o),
        .cmd_valid_i (cmd_valid_i),
        .cmd_opcode_i (cmd_opcode_i),
        .addr_valid_i (addr_valid_i),
        .addr_i (addr_i),
        .op_done_i (op_done_i),
        .busy_o (busy_o),
        .calc_enable_o (calc_enable_o),
        .mem_transfer_o (mem_transfer_o),
        .compare_on_read_o (compare_on_read_o),
        .col_jump_o (col_jump_o),
        .full_jump_o (full_jump_o),
        .page_end_only_o (page_end_only_o),
        .read_per_block_o (read_per_block_o),
        .addr_bit_eight_en_o (addr_bit_eight_en_o),
        .page_blocks_o (page_blocks_o),
        .start_write_o (start_write_o),
        .start_read_o (start_read_o),
        .reposition_o (reposition_o),
        .op_read_o (op_read_o),
        .op_addr_o (op_addr_o)
    );

    nand_flash_model i_mem (
        .ref_clk_i    (ref_clk_i),
        .cmd_valid_o  (cmd_valid_i),
        .cmd_opcode_o (cmd_opcode_i),
        .addr_valid_o (addr_valid_i),
        .addr_o       (addr_i)
    );

    always #5 ref_clk_i = ~ref_clk_i;

    ////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        lfsr_state = {lfsr_state[30:0], 1'b0}
                   ^ (lfsr_state[31] ? 32'h0040_0007 : 32'h0000_0000);
        return lfsr_state;
    endfunction

    function automatic logic [55:0] cap(input logic [55:0] v,
                                        input logic s);
        cap = v;
        if (s)
            cap[8] = 1'b0;
    endfunction

    task automatic chk(input string what, input logic [63:0] seen,
                       input logic [63:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [2:0] idx, input logic [31:0] d);
        @(posedge ref_clk_i);
        #1;
        reg_index_i = idx;
        reg_wdata_i = d;
        reg_write_i = 1'b1;
        @(posedge ref_clk_i);
        #1;
        reg_write_i = 1'b0;
        reg_wdata_i = rnd();
    endtask

    task automatic rd(input logic [2:0] idx, input logic [31:0] e);
        @(posedge ref_clk_i);
        #1;
        reg_index_i = idx;
        reg_read_i  = 1'b1;
        exp_q.push_back(e);
        @(posedge ref_clk_i);
        #1;
        reg_read_i  = 1'b0;
    endtask

    task automatic settle();
        repeat (3) @(posedge ref_clk_i);
        #1;
    endtask

    task automatic done();
        @(posedge ref_clk_i);
        #1;
        op_done_i = 1'b1;
        @(posedge ref_clk_i);
        #1;
        op_done_i = 1'b0;
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // read results come back in order, so the oldest note matches
    always @(negedge ref_clk_i)
    begin
        if (reg_rvalid_o === 1'b1)
            chk("rdata", reg_rdata_o, exp_q.pop_front());
        n_wr  += (start_write_o === 1'b1);
        n_rd  += (start_read_o === 1'b1);
        n_rep += (reposition_o === 1'b1);
    end

    initial
    begin
        #100_000;
        fail_count++;
        close_out();
    end

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        {reg_index_i, reg_write_i, reg_read_i, op_done_i} = '0;
        reg_wdata_i = 32'h0000_0000;
        rst_n_i = 1'b0;
        repeat (8) @(posedge ref_clk_i);
        #1;
        rst_n_i = 1'b1;
        rd(0, 32'h0000_0001);
        rd(1, 32'h0130_0080);
        rd(2, 32'h01E0_0585);
        rd(3, 32'h0000_0000);
        rd(5, 32'h0000_0000);
        rd(6, 32'h0000_0000);
        for (int k = 0; k < 6; k++)
        begin
            r = rnd();
            c = {r[7], 2'(k % 3), r[4], 2'((k + 1) % 3), 2'(k % 3 + 1)};
            wr(0, {24'h00_0000, c});
            settle();
            rd(0, {24'h00_0000, c});
            chk("calc", calc_enable_o, c[3:2] != 2'b00);
            chk("xfer", mem_transfer_o, c[3:2] == 2'b10);
            chk("col", col_jump_o, c[6:5] == 2'b01);
            chk("full", full_jump_o, c[6:5] == 2'b10);
            chk("endonly", page_end_only_o, c[6:5] == 2'b00);
            chk("perblk", read_per_block_o, !c[4]);
            chk("allend", read_per_block_o, c[4] == 1'b0);
            chk("bit8", addr_bit_eight_en_o, !c[7]);
            chk("blocks", page_blocks_o,
                (c[1:0] == 2'b11) ? 3'd4 : {1'b0, c[1:0]});
        end
        wr(0, 32'h0000_008B);
        wr(1, 32'h01A5_3C90);
        settle();
        rd(1, 32'h01A5_3C90);
        i_mem.send_cmd(8'h90);
        a = 56'({rnd(), rnd()});
        a[8] = 1'b1;
        i_mem.send_addr(a);
        settle();
        chk("startw", n_wr, 1);
        chk("busy", busy_o, 1);
        chk("opread", op_read_o, 0);
        chk("addr", op_addr_o, cap(a, 1'b1));
        rd(5, 32'h0000_0040);
        wr(3, 32'hFFFF_FFFF);
        rd(3, 32'(cap(a, 1'b1)));
        rd(4, 32'(cap(a, 1'b1) >> 32));
        // write during busy must be dropped
        wr(0, 32'h0000_0005);
        settle();
        rd(0, 32'h0000_008B);
        done();
        settle();
        chk("idle", busy_o, 0);
        i_mem.send_cmd(8'h3C);
        a = 56'({rnd(), rnd()});
        i_mem.send_addr(a);
        i_mem.send_cmd(8'hA5);
        settle();
        chk("startr", n_rd, 1);
        chk("opread", op_read_o, 1);
        chk("cmpread", compare_on_read_o, 1);
        chk("addr", op_addr_o, cap(a, 1'b1));
        done();
        i_mem.send_cmd(8'h3C);
        i_mem.send_cmd(8'h11);
        i_mem.send_cmd(8'hA5);
        settle();
        chk("abort", n_rd, 1);
        wr(1, 32'h0000_3C90);
        i_mem.send_cmd(8'h3C);
        settle();
        chk("noend", n_rd, 2);
        done();
        wr(0, 32'h0000_0001);
        i_mem.send_cmd(8'h90);
        settle();
        chk("bypass", n_wr, 1);
        wr(0, 32'h0000_0025);
        i_mem.send_cmd(8'h90);
        a = 56'({rnd(), rnd()});
        a[8] = 1'b1;
        i_mem.send_addr(a);
        i_mem.send_cmd(8'h85);
        i_mem.send_cmd(8'h05);
        i_mem.send_cmd(8'hE0);
        settle();
        chk("startw", n_wr, 2);
        chk("repos", n_rep, 2);
        chk("bit8kept", op_addr_o, cap(a, 1'b0));
        done();
        settle();
        chk("queue", exp_q.size(), 0);
        close_out();
    end
endmodule // nand_ecc_config_control_tb_top
